// *** common/u2dp_map.vh ***
// Register offsets, field positions, reset values and timing counts of the UART data port
`ifndef U2DP_MAP_VH
`define U2DP_MAP_VH
// Register byte offsets
`define U2DP_DATA_OFFS      12'h000
`define U2DP_DLH_OFFS       12'h004
`define U2DP_LCR_OFFS       12'h00C
`define U2DP_FCR_OFFS       12'h008
`define U2DP_LSR_OFFS       12'h014
`define U2DP_IST_OFFS       12'h018
`define U2DP_IMSK_OFFS      12'h01C
// Field positions
`define U2DP_LCR_DIVISOR_ACCESS_BIT       7
`define U2DP_FCR_FIFOEN     0
`define U2DP_FCR_RXCLR      1
`define U2DP_FCR_TXCLR      2
`define U2DP_LSR_DR         0
`define U2DP_LSR_OE         1
`define U2DP_LSR_FE         3
`define U2DP_LSR_TX_HOLDING_EMPTY_FLAG       5
`define U2DP_LSR_TEMT       6
// Status event bits
`define U2DP_EV_RX          0
`define U2DP_EV_OVR         1
`define U2DP_EV_TX_HOLDING_EMPTY_FLAG        2
`define U2DP_EV_FRM         3
// Reset values
`define U2DP_DIV_RST        16'h0000
`define U2DP_LCR_RST        8'h00
`define U2DP_FCR_RST        8'h00
// Timing counts
`define U2DP_OVERSAMPLE     16
`define U2DP_SAMPLE_MID     4'h7
`endif

// *** src/u2dp_fifo.v ***
// Byte FIFO used for the receive and transmit paths of the UART data port
module u2dp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk_sys_i,
    input  wire             rst_i,
    input  wire             ce_i,
    input  wire             clr_i,
    input  wire             push_i,
    input  wire [WIDTH-1:0] wdata_i,
    input  wire             pop_i,
    output wire [WIDTH-1:0] rdata_o,
    output wire             empty_o,
    output wire             full_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wptr;
    reg [AW-1:0]    rptr;
    reg [AW:0]      count;
    wire            do_push;
    wire            do_pop;

    assign empty_o = (count == {(AW+1){1'b0}});
    assign full_o  = (count == DEPTH[AW:0]);
    assign rdata_o = mem[rptr];
    // Full refuses a push, so stored data is never disturbed
    assign do_push = push_i && !full_o;
    assign do_pop  = pop_i && !empty_o;

    // ****************************************
    // Pointers and fill level
    // ****************************************
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            wptr  <= {AW{1'b0}};
            rptr  <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else if (ce_i) begin
            if (clr_i) begin
                wptr  <= {AW{1'b0}};
                rptr  <= {AW{1'b0}};
                count <= {(AW+1){1'b0}};
            end else begin
                if (do_push) wptr <= wptr + 1'b1;
                if (do_pop) rptr <= rptr + 1'b1;
                if (do_push && !do_pop) count <= count + 1'b1;
                else if (do_pop && !do_push) count <= count - 1'b1;
            end
        end
    end

    // Storage array
    always @(posedge clk_sys_i) begin
        if (ce_i && do_push && !clr_i) begin
            mem[wptr] <= wdata_i;
        end
    end
endmodule // u2dp_fifo

// *** src/u2dp_uart.v ***
// UART data port with divisor latch, FIFOs, serial engines and APB slave
// Overview of operation
// - A data read returns the received byte, valid while the data-ready flag is set.
// - Without FIFOs a new character overwrites an unread buffer byte and flags overrun.
// - With FIFOs reads pop the head; a full FIFO keeps its data, drops the new one, flags overrun.
// - Without FIFOs a write clears the holding-empty flag and the byte is then sent.
// - Without FIFOs a further write before the flag sets again replaces the pending byte.
// - With FIFOs the transmit FIFO takes 16 characters before it reports full.
// - A write while the transmit FIFO is full is discarded and the FIFO is unchanged.
// - The port holds the low 8 bits of the 16-bit divisor when divisor access is selected.
// - The divisor low byte is reached only while divisor access bit 7 of line control is set.
// - Bit rate is the system clock divided by sixteen times the divisor.
// - With a zero divisor the baud clock stops and no transfer takes place.
`include "u2dp_map.vh"
module u2dp_uart #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW    = 4
) (
    input  wire        clk_sys_i,
    input  wire        rst_i,
    input  wire        ce_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    input  wire        rx_i,
    output reg         tx_o,
    output reg         irq_o
);
    // ****************************************
    // Registers and state
    // ****************************************
    reg  [15:0] divisor;
    reg  [7:0]  line_control_reg;
    reg  [7:0]  fifo_control_reg;
    reg         overrun_flag;
    reg         frame_flag;
    reg  [3:0]  irq_status;
    reg  [3:0]  irq_mask;
    reg  [7:0]  receive_buffer;
    reg         rbuf_full;
    reg  [7:0]  transmit_holding;
    reg         thr_full;
    reg  [15:0] baud_cnt;
    reg         baud_tick;
    // Receiver
    reg  [1:0]  rx_state;
    reg  [3:0]  rx_os;
    reg  [2:0]  rx_bit;
    reg  [7:0]  rx_shift;
    // Transmitter
    reg  [1:0]  tx_state;
    reg  [3:0]  tx_os;
    reg  [2:0]  tx_bit;
    reg  [7:0]  tx_shift;

    localparam ST_IDLE  = 2'd0;
    localparam ST_START = 2'd1;
    localparam ST_DATA  = 2'd2;
    localparam ST_STOP  = 2'd3;

    wire        fifo_en = fifo_control_reg[`U2DP_FCR_FIFOEN];
    wire        divisor_access_bit    = line_control_reg[`U2DP_LCR_DIVISOR_ACCESS_BIT];
    wire        apb_acc = psel_i && penable_i && pready_o;
    wire        apb_wr  = apb_acc && pwrite_i;
    wire        apb_rd  = apb_acc && !pwrite_i;
    wire        data_sel = (paddr_i == `U2DP_DATA_OFFS);
    wire        rx_done;
    wire        tx_load;
    wire [7:0]  rxf_data;
    wire        rxf_empty;
    wire        rxf_full;
    wire [7:0]  txf_data;
    wire        txf_empty;
    wire        txf_full;

    // Address match helper shared by decode and read mux
    function hit;
        input [11:0] a;
        input [11:0] offs;
        begin
            hit = (a == offs);
        end
    endfunction

    // Data-path strobes; data port pop and push are gated by divisor access, the FCR strobes are not
    wire rx_pop  = apb_rd && data_sel && !divisor_access_bit;
    wire tx_push = apb_wr && data_sel && !divisor_access_bit;
    wire fcr_wr  = apb_wr && hit(paddr_i, `U2DP_FCR_OFFS);
    wire rxf_clr = fcr_wr && pwdata_i[`U2DP_FCR_RXCLR];
    wire txf_clr = fcr_wr && pwdata_i[`U2DP_FCR_TXCLR];

    // Receive and transmit path status
    wire data_ready = fifo_en ? !rxf_empty : rbuf_full;
    wire [7:0] rx_head = fifo_en ? rxf_data : receive_buffer;
    wire rx_overrun = rx_done && (fifo_en ? rxf_full : rbuf_full);
    wire tx_holding_empty_flag = fifo_en ? txf_empty : !thr_full;
    wire tx_idle    = (tx_state == ST_IDLE);
    wire [7:0] line_status_reg = {1'b0, tx_holding_empty_flag && tx_idle,
                                  tx_holding_empty_flag, 1'b0, frame_flag,
                                  1'b0, overrun_flag, data_ready};

    // ****************************************
    // FIFOs
    // ****************************************
    u2dp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rxf (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .clr_i     (rxf_clr || !fifo_en),
        .push_i    (rx_done && fifo_en),
        .wdata_i   (rx_shift),
        .pop_i     (rx_pop && fifo_en),
        .rdata_o   (rxf_data),
        .empty_o   (rxf_empty),
        .full_o    (rxf_full)
    );

    u2dp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_txf (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .clr_i     (txf_clr || !fifo_en),
        .push_i    (tx_push && fifo_en),
        .wdata_i   (pwdata_i[7:0]),
        .pop_i     (tx_load && fifo_en),
        .rdata_o   (txf_data),
        .empty_o   (txf_empty),
        .full_o    (txf_full)
    );

    // ****************************************
    // Baud generator: one tick per sixteenth of a bit
    // ****************************************
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            baud_cnt  <= 16'h0000;
            baud_tick <= 1'b0;
        end else if (ce_i) begin
            if (divisor == 16'h0000) begin
                baud_cnt  <= 16'h0000;
                baud_tick <= 1'b0;
            end else if (baud_cnt >= divisor - 16'h0001) begin
                baud_cnt  <= 16'h0000;
                baud_tick <= 1'b1;
            end else begin
                baud_cnt  <= baud_cnt + 16'h0001;
                baud_tick <= 1'b0;
            end
        end
    end

    // ****************************************
    // Receiver: start detect, mid-bit sampling, 8N1
    // ****************************************
    assign rx_done = baud_tick && (rx_state == ST_STOP) && (rx_os == 4'hF) && rx_i;

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rx_state   <= ST_IDLE;
            rx_os      <= 4'h0;
            rx_bit     <= 3'd0;
            rx_shift   <= 8'h00;
            frame_flag <= 1'b0;
        end else if (ce_i) begin
            if (apb_rd && hit(paddr_i, `U2DP_LSR_OFFS)) frame_flag <= 1'b0;
            if (baud_tick) begin
                case (rx_state)
                    ST_IDLE: begin
                        rx_os <= 4'h0;
                        if (!rx_i) rx_state <= ST_START;
                    end
                    ST_START: begin
                        rx_os <= rx_os + 4'h1;
                        if (rx_os == `U2DP_SAMPLE_MID) begin
                            rx_os    <= 4'h0;
                            rx_bit   <= 3'd0;
                            rx_state <= rx_i ? ST_IDLE : ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        rx_os <= rx_os + 4'h1;
                        if (rx_os == 4'hF) begin
                            rx_shift <= {rx_i, rx_shift[7:1]};
                            rx_bit   <= rx_bit + 3'd1;
                            if (rx_bit == 3'd7) rx_state <= ST_STOP;
                        end
                    end
                    ST_STOP: begin
                        rx_os <= rx_os + 4'h1;
                        if (rx_os == 4'hF) begin
                            rx_state <= ST_IDLE;
                            if (!rx_i) frame_flag <= 1'b1;
                        end
                    end
                    default: rx_state <= ST_IDLE;
                endcase
            end
        end
    end

    // Non-FIFO receive buffer; overwrite wins over a same-cycle read
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            receive_buffer <= 8'h00;
            rbuf_full      <= 1'b0;
            overrun_flag   <= 1'b0;
        end else if (ce_i) begin
            if (rx_done && !fifo_en) begin
                receive_buffer <= rx_shift;
                rbuf_full      <= 1'b1;
            end else if (rx_pop && !fifo_en) begin
                rbuf_full      <= 1'b0;
            end
            if (rx_overrun) overrun_flag <= 1'b1;
            else if (apb_rd && hit(paddr_i, `U2DP_LSR_OFFS)) overrun_flag <= 1'b0;
        end
    end

    // ****************************************
    // Transmitter: holding register or FIFO feeds the shifter
    // ****************************************
    assign tx_load = baud_tick && tx_idle && tx_os == 4'hF && (fifo_en ? !txf_empty : thr_full);

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            transmit_holding <= 8'h00;
            thr_full         <= 1'b0;
        end else if (ce_i) begin
            if (tx_push && !fifo_en) begin
                transmit_holding <= pwdata_i[7:0];
                thr_full         <= 1'b1;
            end else if (tx_load && !fifo_en) begin
                thr_full         <= 1'b0;
            end
        end
    end

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tx_state <= ST_IDLE;
            tx_os    <= 4'h0;
            tx_bit   <= 3'd0;
            tx_shift <= 8'h00;
            tx_o     <= 1'b1;
        end else if (ce_i && baud_tick) begin
            tx_os <= tx_os + 4'h1;
            case (tx_state)
                ST_IDLE: begin
                    tx_o <= 1'b1;
                    if (tx_load) begin
                        tx_shift <= fifo_en ? txf_data : transmit_holding;
                        tx_state <= ST_START;
                        tx_o     <= 1'b0;
                    end
                end
                ST_START: begin
                    if (tx_os == 4'hF) begin
                        tx_state <= ST_DATA;
                        tx_bit   <= 3'd0;
                        tx_o     <= tx_shift[0];
                    end
                end
                ST_DATA: begin
                    if (tx_os == 4'hF) begin
                        tx_shift <= {1'b0, tx_shift[7:1]};
                        tx_bit   <= tx_bit + 3'd1;
                        tx_o     <= (tx_bit == 3'd7) ? 1'b1 : tx_shift[1];
                        if (tx_bit == 3'd7) tx_state <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (tx_os == 4'hF) tx_state <= ST_IDLE;
                end
                default: tx_state <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Control registers and interrupt status
    // ****************************************
    // Framing event: stop bit sampled low at the end of a frame
    wire       frm_ev = baud_tick && (rx_state == ST_STOP) && (rx_os == 4'hF) && !rx_i;
    wire [3:0] ev = {frm_ev, tx_load, rx_overrun, rx_done};

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            divisor          <= `U2DP_DIV_RST;
            line_control_reg <= `U2DP_LCR_RST;
            fifo_control_reg <= `U2DP_FCR_RST;
            irq_mask         <= 4'h0;
            irq_status       <= 4'h0;
            irq_o            <= 1'b0;
        end else if (ce_i) begin
            if (apb_wr && data_sel && divisor_access_bit) divisor[7:0] <= pwdata_i[7:0];
            if (apb_wr && hit(paddr_i, `U2DP_DLH_OFFS) && divisor_access_bit) divisor[15:8] <= pwdata_i[7:0];
            if (apb_wr && hit(paddr_i, `U2DP_LCR_OFFS)) line_control_reg <= pwdata_i[7:0];
            if (fcr_wr) fifo_control_reg <= {7'h00, pwdata_i[`U2DP_FCR_FIFOEN]};
            if (apb_wr && hit(paddr_i, `U2DP_IMSK_OFFS)) irq_mask <= pwdata_i[3:0];
            // Set wins over write-one-to-clear
            irq_status <= (irq_status & ~((apb_wr && hit(paddr_i, `U2DP_IST_OFFS)) ?
                          pwdata_i[3:0] : 4'h0)) | ev;
            irq_o <= |(irq_status & irq_mask);
        end
    end

    // ****************************************
    // APB slave: one wait state, read data registered
    // ****************************************
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o  <= 32'h00000000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (ce_i) begin
            pready_o  <= psel_i && penable_i && !pready_o;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
            if (psel_i && penable_i && !pready_o && !pwrite_i) begin
                if (data_sel) prdata_o <= {24'h000000, divisor_access_bit ? divisor[7:0] : rx_head};
                else if (hit(paddr_i, `U2DP_DLH_OFFS))
                    prdata_o <= {24'h000000, divisor_access_bit ? divisor[15:8] : 8'h00};
                else if (hit(paddr_i, `U2DP_LCR_OFFS)) prdata_o <= {24'h000000, line_control_reg};
                else if (hit(paddr_i, `U2DP_FCR_OFFS)) prdata_o <= {24'h000000, fifo_control_reg};
                else if (hit(paddr_i, `U2DP_LSR_OFFS)) prdata_o <= {24'h000000, line_status_reg};
                else if (hit(paddr_i, `U2DP_IST_OFFS)) prdata_o <= {28'h0000000, irq_status};
                else if (hit(paddr_i, `U2DP_IMSK_OFFS)) prdata_o <= {28'h0000000, irq_mask};
                else pslverr_o <= 1'b1;
            end
        end
    end
endmodule // u2dp_uart

// *** verif/u2dp_peer.sv ***
// Remote serial transceiver facing the UART data port
module u2dp_peer (
    input  wire        clk_sys_i,
    input  wire [15:0] bit_clks_i,
    input  wire        tx_i,
    output logic       rx_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got_q[$];
    initial rx_o = 1'b1;
    // Send one 8N1 frame, LSB first; line stays high afterwards
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_o <= f[i];
            repeat (bit_clks_i) @(posedge clk_sys_i);
        end
    endtask
    // Receive frames, sampling each bit at its middle; bad stop bit drops the frame
    initial forever begin : rx_frame
        logic [7:0] b;
        @(negedge tx_i);
        repeat (bit_clks_i / 2) @(posedge clk_sys_i);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_clks_i) @(posedge clk_sys_i);
            b[i] = tx_i;
        end
        repeat (bit_clks_i) @(posedge clk_sys_i);
        if (tx_i === 1'b1)
            got_q.push_back(b);
    end
endmodule // u2dp_peer

// *** verif/u2dp_uart_props.sv ***
// Concurrent checks on the ports of the UART data port
module u2dp_uart_props (
    input wire        clk_sys_i,
    input wire        rst_i,
    input wire        ce_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire        pready_o,
    input wire        pslverr_o,
    input wire        rx_i,
    input wire        tx_o,
    input wire        irq_o
);
    int low_run;
    // Length of the current low run on the serial output
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i || tx_o)
            low_run <= 0;
        else
            low_run <= low_run + 1;
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // Bus phases
    sequence s_setup;
        psel_i && !penable_i && ce_i;
    endsequence
    sequence s_access;
        psel_i && penable_i && !pready_o && ce_i;
    endsequence
    a_ready_one_wait: assert property (s_setup ##1 s_access |=> pready_o)
        else $error("answer not one cycle after access");
    a_ready_one_cycle: assert property (pready_o |=> !pready_o)
        else $error("answer longer than one cycle");
    a_ready_has_cause: assert property (pready_o |-> $past(psel_i && penable_i))
        else $error("answer without access");
    a_rdata_zero_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
        else $error("read data not zero outside answer");
    a_err_only_read: assert property (pslverr_o |-> pready_o && !pwrite_i)
        else $error("error outside a read answer");
    a_err_unmapped_read: assert property (pready_o && !pwrite_i && paddr_i == 12'h010
        |-> pslverr_o)
        else $error("unmapped read without error");
    a_data_read_ok: assert property (pready_o && paddr_i == 12'h000 |-> !pslverr_o)
        else $error("data port access flagged");
    a_bit_time_whole: assert property ($rose(tx_o) |-> low_run[3:0] == 4'h0)
        else $error("low run not whole bit times");
endmodule // u2dp_uart_props

bind u2dp_uart u2dp_uart_props u_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .rx_i(rx_i), .tx_o(tx_o), .irq_o(irq_o));

// *** verif/u2dp_uart_tb.sv ***
// Self-checking testbench of the UART data port
`include "u2dp_map.vh"
module u2dp_uart_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BITC = 16; // Clocks per bit at divisor one
    logic        clk_sys_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic        ce_i      = 1'b1;
    logic        psel_i    = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i  = 1'b0;
    logic [11:0] paddr_i   = 12'h000;
    logic [31:0] pwdata_i  = 32'h0000_0000;
    logic [31:0] prdata_o;
    logic        pready_o, pslverr_o, rx_i, tx_o, irq_o, last_err;
    int          n_tests    = 0;
    int          n_mismatch = 0;

    u2dp_uart dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_i(rx_i),
        .tx_o(tx_o), .irq_o(irq_o));
    u2dp_peer peer_u (.clk_sys_i(clk_sys_i), .bit_clks_i(16'(BITC)), .tx_i(tx_o),
        .rx_o(rx_i));

    // 25 MHz clock
    always #20 clk_sys_i = ~clk_sys_i;

    // ****************
    // Helpers
    // ****************
    task automatic fail(input string m);
        n_mismatch++;
        $display("BAD %0t %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        n_tests++;
        if (g !== e)
            fail(m);
    endtask
    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        logic rdy;
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
            rdy = pready_o;
        end while (rdy !== 1'b1 && n < 50);
        r = prdata_o;
        last_err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        if (rdy !== 1'b1) begin
            fail("no bus answer");
            tally_and_finish();
        end
        @(posedge clk_sys_i);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        apb(1'b0, a, 32'h0000_0000, r);
    endtask
    // Poll one line status bit until it shows the wanted value
    task automatic wait_lsr(input int b, input logic v);
        logic [31:0] r;
        int k;
        k = 0;
        do begin
            rd(`U2DP_LSR_OFFS, r);
            k++;
        end while (r[b] !== v && k < 500);
        if (r[b] !== v) begin
            fail("status wait ran out");
            tally_and_finish();
        end
    endtask
    task automatic wait_got(input int n);
        int k;
        k = 0;
        while (peer_u.got_q.size() < n && k < 5000) begin
            @(posedge clk_sys_i);
            k++;
        end
        repeat (300) @(posedge clk_sys_i);
        chk(peer_u.got_q.size(), n, "sent frame count");
    endtask

    // ****************
    // Scenarios
    // ****************
    task automatic t_divisor();
        logic [31:0] r;
        peer_u.send(8'h5A);
        rd(`U2DP_LSR_OFFS, r);
        chk(r[`U2DP_LSR_DR], 1'b0, "received with zero divisor");
        chk(tx_o, 1'b1, "line active with zero divisor");
        wr(`U2DP_LCR_OFFS, 32'h0000_0080);
        rd(`U2DP_DATA_OFFS, r);
        chk(r[7:0], 8'h00, "divisor low reset");
        wr(`U2DP_DATA_OFFS, 32'h0000_00A5);
        rd(`U2DP_DATA_OFFS, r);
        chk(r[7:0], 8'hA5, "divisor low readback");
        wr(`U2DP_DATA_OFFS, 32'h0000_0001);
        wr(`U2DP_DLH_OFFS, 32'h0000_0000);
        wr(`U2DP_LCR_OFFS, 32'h0000_0000);
        repeat (8 * BITC) @(posedge clk_sys_i);
        rd(12'h010, r);
        chk(last_err, 1'b1, "unmapped read not flagged");
        $display("divisor test done");
    endtask
    task automatic t_tx_hold();
        logic [31:0] r;
        wait_lsr(`U2DP_LSR_TX_HOLDING_EMPTY_FLAG, 1'b1);
        wr(`U2DP_DATA_OFFS, 32'h0000_003C);
        wait_lsr(`U2DP_LSR_TX_HOLDING_EMPTY_FLAG, 1'b1);
        wr(`U2DP_DATA_OFFS, 32'h0000_0081);
        rd(`U2DP_LSR_OFFS, r);
        chk(r[`U2DP_LSR_TX_HOLDING_EMPTY_FLAG], 1'b0, "holding flag not cleared");
        wr(`U2DP_DATA_OFFS, 32'h0000_00E7);
        wait_got(2);
        chk(peer_u.got_q[0], 8'h3C, "first byte");
        chk(peer_u.got_q[1], 8'hE7, "replaced byte");
        wr(`U2DP_LCR_OFFS, 32'h0000_0080);
        rd(`U2DP_DATA_OFFS, r);
        chk(r[7:0], 8'h01, "data write reached divisor");
        wr(`U2DP_LCR_OFFS, 32'h0000_0000);
        $display("holding test done");
    endtask
    task automatic t_tx_fifo();
        peer_u.got_q.delete();
        wr(`U2DP_FCR_OFFS, 32'h0000_0001);
        for (int i = 0; i < 18; i++)
            wr(`U2DP_DATA_OFFS, 32'(i));
        wait_got(17);
        for (int i = 0; i < 17; i++)
            chk(peer_u.got_q[i], 8'(i), "fifo byte order");
        $display("tx fifo test done");
    endtask
    task automatic t_rx();
        logic [31:0] r;
        wr(`U2DP_FCR_OFFS, 32'h0000_0000);
        wr(`U2DP_IMSK_OFFS, 32'h0000_0000);
        peer_u.send(8'h5A);
        wait_lsr(`U2DP_LSR_DR, 1'b1);
        chk(irq_o, 1'b0, "masked interrupt raised");
        wr(`U2DP_IMSK_OFFS, 32'h0000_0001);
        repeat (2) @(posedge clk_sys_i);
        chk(irq_o, 1'b1, "interrupt missing");
        rd(`U2DP_DATA_OFFS, r);
        chk(r[7:0], 8'h5A, "received byte");
        rd(`U2DP_LSR_OFFS, r);
        chk(r[`U2DP_LSR_DR], 1'b0, "ready flag stuck");
        wr(`U2DP_IST_OFFS, 32'h0000_000F);
        repeat (2) @(posedge clk_sys_i);
        chk(irq_o, 1'b0, "interrupt not cleared");
        peer_u.send(8'h11);
        peer_u.send(8'h22);
        repeat (4) @(posedge clk_sys_i);
        rd(`U2DP_LSR_OFFS, r);
        chk(r[1:0], 2'b11, "overrun not flagged");
        rd(`U2DP_DATA_OFFS, r);
        chk(r[7:0], 8'h22, "buffer not overwritten");
        wr(`U2DP_IST_OFFS, 32'h0000_000F);
        $display("rx buffer test done");
    endtask
    task automatic t_rx_fifo();
        logic [31:0] r;
        wr(`U2DP_FCR_OFFS, 32'h0000_0001);
        for (int i = 0; i < 17; i++)
            peer_u.send(8'h40 + 8'(i));
        repeat (4) @(posedge clk_sys_i);
        rd(`U2DP_LSR_OFFS, r);
        chk(r[`U2DP_LSR_OE], 1'b1, "fifo overrun not flagged");
        for (int i = 0; i < 16; i++) begin
            rd(`U2DP_DATA_OFFS, r);
            chk(r[7:0], 8'h40 + 8'(i), "fifo head byte");
        end
        rd(`U2DP_LSR_OFFS, r);
        chk(r[`U2DP_LSR_DR], 1'b0, "ready after drain");
        $display("rx fifo test done");
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        t_divisor();
        t_tx_hold();
        t_tx_fifo();
        t_rx();
        t_rx_fifo();
        tally_and_finish();
    end
endmodule // u2dp_uart_tb
